//--- core/ramp_guard_defines.svh
// Constants for the ramp protection and input terminal block
`ifndef RAMP_GUARD_DEFINES_SVH
`define RAMP_GUARD_DEFINES_SVH
// Register offsets (word index = byte address / 4)
`define RG_ADDR_CTRL      8'h00
`define RG_ADDR_PGAIN     8'h04
`define RG_ADDR_ITIME     8'h08
`define RG_ADDR_DTIME     8'h0C
`define RG_ADDR_THRESH    8'h10
`define RG_ADDR_FUNC_LO   8'h14
`define RG_ADDR_FUNC_HI   8'h18
`define RG_ADDR_STATUS    8'h1C
// Control bit positions
`define RG_CTRL_BUS_REG   0
`define RG_CTRL_CUR_SUP   1
`define RG_CTRL_CARRIER   2
`define RG_CTRL_READY     3
`define RG_CTRL_HV_CLASS  4
`define RG_CTRL_NC_LSB    8
// Gain in tenths, times in tenths of a second, volts in whole volts
`define RG_PGAIN_MIN      16'h0002
`define RG_PGAIN_MAX      16'h0032
`define RG_PGAIN_RST      16'h0002
`define RG_ITIME_MAX      16'h05DC
`define RG_ITIME_RST      16'h0002
`define RG_DTIME_MAX      16'h03E8
`define RG_DTIME_RST      16'h0000
`define RG_THR_LV_MIN     16'h014A
`define RG_THR_LV_MAX     16'h018B
`define RG_THR_LV_RST     16'h017C
`define RG_THR_HV_MIN     16'h0294
`define RG_THR_HV_MAX     16'h0316
`define RG_THR_HV_RST     16'h02F8
// Current guard: 150 percent of rated, in percent of rated
`define RG_CUR_LIMIT_PCT  16'h0096
// Function code of the thermistor input
`define RG_FUNC_THERM     5'h13
`define RG_FUNC_COUNT     31
// Default terminal functions
`define RG_FUNC_DEFAULTS  25'h0918820
`endif

//--- core/ramp_guard_pkg.sv
// Types for the ramp protection and input terminal block
package ramp_guard_pkg;
	// Measured quantities from the power stage
	typedef struct packed {
		logic [15:0] bus_volts;
		logic [15:0] current_pct;
		logic [15:0] load_level;
		logic        update;
	} meas_s;
	// Ramp commands to the frequency generator
	typedef struct packed {
		logic accel_hold;
		logic decel_hold;
		logic [15:0] decel_stretch;
	} ramp_s;
	typedef enum logic [1:0] {
		REG_IDLE  = 2'b00,
		REG_ACT   = 2'b01,
		REG_HOLD  = 2'b10
	} reg_state_e;
endpackage

//--- core/ramp_guard.sv
// Ramp protection, carrier/ready options and input terminal decoder
// How it works
// RULE1: Bus regulation stretches decel below trip level.
// RULE2: Proportional gain accepted 0.2 to 5.0.
// RULE3: Integration time accepted 0.0 to 150.0.
// RULE4: Derivative time accepted 0.0 to 100.0.
// RULE5: Regulation starts above threshold, class ranges.
// RULE6: Current suppression holds accel above 150%.
// RULE7: Current suppression also holds deceleration.
// RULE8: Suppression pauses ramps, never regulates current.
// RULE9: Carrier mode lowers carrier at load limit.
// RULE10: Ready option keeps output stage energised.
// RULE11: Each terminal selects one of 31 functions.
// RULE12: Inputs are two-state, OFF 0 ON 1.
// RULE13: Shared function is OR of its terminals.
// RULE14: Code 19 on terminal five is thermistor.
// RULE15: Normally closed inverts level before decoding.
// RULE16: Hold conditions re-evaluated each control update.
//
// Design decisions made here: the register addresses and the strobed register port.
`include "ramp_guard_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module ramp_guard
	import ramp_guard_pkg::*;
#(
	parameter logic [15:0] LOAD_LIMIT = 16'h0064
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Power stage measurements
	input  wire meas_s       meas_i,
	input  wire logic        run_i,
	// Terminal pins, asynchronous
	input  wire logic [4:0]  term_pin_i,
	// Ramp and stage control
	output ramp_s            ramp_o,
	output logic             carrier_low_o,
	output logic             stage_enable_o,
	output logic             thermistor_sel_o,
	output logic [30:0]      func_active_o
);
	// Settings
	logic [15:0] pgain_r;        // Gain in tenths
	logic [15:0] itime_r;        // Tenths of a second
	logic [15:0] dtime_r;        // Tenths of a second
	logic [15:0] thresh_r;       // Volts
	logic        bus_sel_r;      // Bus regulation enable
	logic        cur_sel_r;      // Current suppression enable
	logic        car_sel_r;      // Carrier reduction enable
	logic        rdy_sel_r;      // Output ready enable
	logic        hv_r;           // Higher voltage class
	logic [4:0]  nc_r;           // Normally closed per terminal
	logic [24:0] func_r;         // Five 5-bit function codes
	reg_state_e  state_r;        // Regulator state
	logic [15:0] integ_r;        // Integral accumulator
	logic [15:0] err_prev_r;     // Previous error for D term
	logic [4:0]  sync1_r;        // Synchroniser stage one
	logic [4:0]  sync2_r;        // Synchroniser stage two
	logic [15:0] err;            // Overvoltage above threshold
	logic        over_v;
	logic        over_i;

	// Clamp a written value into its legal range
	function automatic logic [15:0] clamp(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		return v;
	endfunction

	// Settings writes; out-of-range values are clamped, not rejected
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pgain_r   <= `RG_PGAIN_RST;
			itime_r   <= `RG_ITIME_RST;
			dtime_r   <= `RG_DTIME_RST;
			thresh_r  <= `RG_THR_LV_RST;
			bus_sel_r <= 1'b0;
			cur_sel_r <= 1'b0;
			car_sel_r <= 1'b0;
			rdy_sel_r <= 1'b0;
			hv_r      <= 1'b0;
			nc_r      <= 5'h00;
			func_r    <= `RG_FUNC_DEFAULTS;
		end else if (wr_i) begin
			case (addr_i)
				`RG_ADDR_CTRL: begin
					bus_sel_r <= wdata_i[`RG_CTRL_BUS_REG];
					cur_sel_r <= wdata_i[`RG_CTRL_CUR_SUP];
					car_sel_r <= wdata_i[`RG_CTRL_CARRIER];
					rdy_sel_r <= wdata_i[`RG_CTRL_READY];
					// Class change reloads the class default threshold
					if (hv_r != wdata_i[`RG_CTRL_HV_CLASS])
						thresh_r <= wdata_i[`RG_CTRL_HV_CLASS] ?
							`RG_THR_HV_RST : `RG_THR_LV_RST;
					hv_r      <= wdata_i[`RG_CTRL_HV_CLASS];
					nc_r      <= wdata_i[`RG_CTRL_NC_LSB +: 5]; // see RULE15
				end
				`RG_ADDR_PGAIN:                                       // see RULE2
					pgain_r <= clamp(wdata_i[15:0], `RG_PGAIN_MIN,
						`RG_PGAIN_MAX);
				`RG_ADDR_ITIME:                                       // see RULE3
					itime_r <= clamp(wdata_i[15:0], 16'h0000,
						`RG_ITIME_MAX);
				`RG_ADDR_DTIME:                                       // see RULE4
					dtime_r <= clamp(wdata_i[15:0], 16'h0000,
						`RG_DTIME_MAX);
				`RG_ADDR_THRESH:                                      // see RULE5
					thresh_r <= hv_r ?
						clamp(wdata_i[15:0], `RG_THR_HV_MIN, `RG_THR_HV_MAX) :
						clamp(wdata_i[15:0], `RG_THR_LV_MIN, `RG_THR_LV_MAX);
				`RG_ADDR_FUNC_LO:                                     // see RULE11
					func_r[14:0] <= wdata_i[14:0];
				`RG_ADDR_FUNC_HI:
					func_r[24:15] <= wdata_i[9:0];
				default: begin
				end
			endcase
		end
	end

	// Instant comparisons against the limits
	assign over_v = meas_i.bus_volts > thresh_r;                    // see RULE5
	assign over_i = meas_i.current_pct > `RG_CUR_LIMIT_PCT;          // see RULE6
	assign err    = over_v ? meas_i.bus_volts - thresh_r : 16'h0000;

	// Regulator state, advanced only on a control update
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r    <= REG_IDLE;
			integ_r    <= 16'h0000;
			err_prev_r <= 16'h0000;
		end else if (meas_i.update) begin                          // see RULE16
			err_prev_r <= err;
			case (state_r)
				REG_IDLE:
					if (bus_sel_r && over_v)                         // see RULE1
						state_r <= REG_ACT;
				REG_ACT: begin
					// Integral grows by one per update for any non-zero time setting, holding at 16'hFFFF
					if (itime_r != 16'h0000 && integ_r != 16'hFFFF)
						integ_r <= integ_r + 16'h0001;
					if (!bus_sel_r || !over_v)
						state_r <= REG_HOLD;
				end
				REG_HOLD: begin
					integ_r <= 16'h0000;
					state_r <= (bus_sel_r && over_v) ? REG_ACT : REG_IDLE;
				end
				default:
					state_r <= REG_IDLE;
			endcase
		end
	end

	// Ramp commands; suppression only pauses, it never sets current
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ramp_o <= '0;
		end else if (meas_i.update) begin                          // see RULE16
			ramp_o.accel_hold <= cur_sel_r && over_i;                // see RULE6
			ramp_o.decel_hold <= (cur_sel_r && over_i) ||            // see RULE7
				(bus_sel_r && over_v);                                // see RULE1
			ramp_o.decel_stretch <= (bus_sel_r && state_r == REG_ACT) ?
				16'((pgain_r * err) >> 4) + 16'(integ_r >> 4) +
				16'(dtime_r != 16'h0000 && err > err_prev_r ?
					err - err_prev_r : 16'h0000) : 16'h0000;     // see RULE8
		end
	end

	// Carrier reduction and ready output
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			carrier_low_o  <= 1'b0;
			stage_enable_o <= 1'b0;
		end else begin
			carrier_low_o  <= car_sel_r &&
				meas_i.load_level >= LOAD_LIMIT;                      // see RULE9
			stage_enable_o <= run_i || rdy_sel_r;                     // see RULE10
		end
	end

	// Two-flop synchroniser for the terminal pins
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
		end else begin
			sync1_r <= term_pin_i;
			sync2_r <= sync1_r;
		end
	end

	// Function decode: polarity first, then OR of all terminals per code
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			func_active_o    <= 31'h0;
			thermistor_sel_o <= 1'b0;
		end else begin
			for (int f = 0; f < `RG_FUNC_COUNT; f++) begin
				logic hit;
				hit = 1'b0;
				for (int t = 0; t < 5; t++) begin
					// Terminal five as thermistor is not a logic input
					if (func_r[t*5 +: 5] == 5'(f) && !(t == 4 &&
						func_r[24:20] == `RG_FUNC_THERM))             // see RULE14
						hit = hit | (sync2_r[t] ^ nc_r[t]);  // see RULE12
				end
				func_active_o[f] <= hit;                              // see RULE13
			end
			thermistor_sel_o <= func_r[24:20] == `RG_FUNC_THERM;      // see RULE14
		end
	end

	// Register read data, valid the cycle after the read strobe
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i) begin
			case (addr_i)
				`RG_ADDR_CTRL:    rdata_o <= {19'h0, nc_r, 3'h0, hv_r,
					rdy_sel_r, car_sel_r, cur_sel_r, bus_sel_r};
				`RG_ADDR_PGAIN:   rdata_o <= {16'h0, pgain_r};
				`RG_ADDR_ITIME:   rdata_o <= {16'h0, itime_r};
				`RG_ADDR_DTIME:   rdata_o <= {16'h0, dtime_r};
				`RG_ADDR_THRESH:  rdata_o <= {16'h0, thresh_r};
				`RG_ADDR_FUNC_LO: rdata_o <= {17'h0, func_r[14:0]};
				`RG_ADDR_FUNC_HI: rdata_o <= {22'h0, func_r[24:15]};
				`RG_ADDR_STATUS:  rdata_o <= {23'h0, sync2_r, carrier_low_o,
					ramp_o.decel_hold, ramp_o.accel_hold, state_r == REG_ACT};
				default:          rdata_o <= 32'h0;
			endcase
		end else begin
			rdata_o <= 32'h0;
		end
	end

	// Checks
	sequence s_overcur;
		meas_i.update && cur_sel_r && over_i;
	endsequence
	property p_accel_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		s_overcur |=> ramp_o.accel_hold && ramp_o.decel_hold;
	endproperty
	a_accel_hold: assert property (p_accel_hold) // see RULE6
		else $error("accel hold missing under over-current");
	property p_no_hold_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		meas_i.update && !cur_sel_r |=> !ramp_o.accel_hold;
	endproperty
	a_no_hold_off: assert property (p_no_hold_off) // see RULE16
		else $error("accel held while suppression off");
	property p_bus_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		meas_i.update && bus_sel_r && over_v |=> ramp_o.decel_hold;
	endproperty
	a_bus_hold: assert property (p_bus_hold) // see RULE1
		else $error("decel not held over threshold");
	property p_ready;
		@(posedge ref_clk_i) disable iff (rst_i)
		rdy_sel_r |=> stage_enable_o;
	endproperty
	a_ready: assert property (p_ready) // see RULE10
		else $error("stage not energised with ready set");
	property p_carrier;
		@(posedge ref_clk_i) disable iff (rst_i)
		!car_sel_r |=> !carrier_low_o;
	endproperty
	a_carrier: assert property (p_carrier) // see RULE9
		else $error("carrier lowered while disabled");
	property p_thermistor;
		@(posedge ref_clk_i) disable iff (rst_i)
		thermistor_sel_o |-> !func_active_o[`RG_FUNC_THERM];
	endproperty
	a_thermistor: assert property (p_thermistor) // see RULE14
		else $error("thermistor terminal decoded as logic");
	property p_pgain;
		@(posedge ref_clk_i) disable iff (rst_i)
		pgain_r >= `RG_PGAIN_MIN && pgain_r <= `RG_PGAIN_MAX;
	endproperty
	a_pgain: assert property (p_pgain) // see RULE2
		else $error("gain out of range");
	property p_thresh;
		@(posedge ref_clk_i) disable iff (rst_i)
		hv_r ? thresh_r >= `RG_THR_HV_MIN : thresh_r <= `RG_THR_LV_MAX;
	endproperty
	a_thresh: assert property (p_thresh) // see RULE5
		else $error("threshold outside class range");
endmodule
`default_nettype wire

//--- sim/power_stage_model.sv
// Behavioural power stage: reports bus volts, current and load periodically
`timescale 1ns/1ns
`default_nettype none
module power_stage_model
	import ramp_guard_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Quantities the stage is made to show
	input  wire logic [15:0] volts_i,
	input  wire logic [15:0] cur_i,
	input  wire logic [15:0] load_i,
	// Measurement frame to the block
	output meas_s            meas_o
);
	logic [2:0] div_r; // Sample divider, one update in eight cycles
	// Sampled measurements with a one-cycle update pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r  <= 3'h0;
			meas_o <= '0;
		end else begin
			div_r              <= div_r + 3'h1;
			meas_o.bus_volts   <= volts_i;
			meas_o.current_pct <= cur_i;
			meas_o.load_level  <= load_i;
			meas_o.update      <= (div_r == 3'h7);
		end
	end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the ramp protection and terminal block
`include "ramp_guard_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import ramp_guard_pkg::*;
	logic        ref_clk_i = 1'b0; // 20 MHz system clock
	logic        rst_i     = 1'b1; // Held high through the first cycles
	logic [7:0]  addr_i    = 8'h00;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [31:0] rdata_o;
	meas_s       meas_i;
	logic        run_i     = 1'b0;
	logic [4:0]  term_pin_i = 5'h00;
	ramp_s       ramp_o;
	logic        carrier_low_o;
	logic        stage_enable_o;
	logic        thermistor_sel_o;
	logic [30:0] func_active_o;
	logic [15:0] volts = 16'h0000; // Stage settings driven by the bench
	logic [15:0] cur   = 16'h0000;
	logic [15:0] load  = 16'h0000;
	int          num_errors = 0;
	int          n_checks   = 0;
	logic [31:0] rv;
	always #25 ref_clk_i = ~ref_clk_i;
	ramp_guard uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.meas_i(meas_i), .run_i(run_i), .term_pin_i(term_pin_i),
		.ramp_o(ramp_o), .carrier_low_o(carrier_low_o),
		.stage_enable_o(stage_enable_o),
		.thermistor_sel_o(thermistor_sel_o), .func_active_o(func_active_o));
	power_stage_model stage (.clk_i(ref_clk_i), .rst_i(rst_i),
		.volts_i(volts), .cur_i(cur), .load_i(load), .meas_o(meas_i));
	// Verdict and end of run
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compare with case equality so unknowns never match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
	endtask
	// Read strobe, data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, rv);
		chk(rv, e);
	endtask
	// Bounds the whole run in case a step stalls
	initial begin
		tick(20000);
		num_errors++;
		complete_run();
	end
	initial begin
		rst_i = 1'b1;
		tick(16);
		rst_i <= 1'b0;
		// Reset values of every setting and the unmapped hole
		rchk(`RG_ADDR_CTRL, 32'h0);
		rchk(`RG_ADDR_PGAIN, 32'h2);
		rchk(`RG_ADDR_ITIME, 32'h2);
		rchk(`RG_ADDR_DTIME, 32'h0);
		rchk(`RG_ADDR_THRESH, 32'h17C);
		rchk(`RG_ADDR_FUNC_LO, 32'h820);
		rchk(`RG_ADDR_FUNC_HI, 32'h123);
		rchk(8'h40, 32'h0);
		// Range limits of the regulator settings
		wr(`RG_ADDR_PGAIN, 32'h1);
		rchk(`RG_ADDR_PGAIN, 32'h2);
		wr(`RG_ADDR_PGAIN, 32'h33);
		rchk(`RG_ADDR_PGAIN, 32'h32);
		wr(`RG_ADDR_ITIME, 32'h5DD);
		rchk(`RG_ADDR_ITIME, 32'h5DC);
		wr(`RG_ADDR_DTIME, 32'h3E9);
		rchk(`RG_ADDR_DTIME, 32'h3E8);
		wr(`RG_ADDR_THRESH, 32'h149);
		rchk(`RG_ADDR_THRESH, 32'h14A);
		wr(`RG_ADDR_THRESH, 32'h18C);
		rchk(`RG_ADDR_THRESH, 32'h18B);
		wr(`RG_ADDR_CTRL, 32'h10);
		rchk(`RG_ADDR_THRESH, 32'h2F8);
		wr(`RG_ADDR_THRESH, 32'h293);
		rchk(`RG_ADDR_THRESH, 32'h294);
		wr(`RG_ADDR_THRESH, 32'h317);
		rchk(`RG_ADDR_THRESH, 32'h316);
		wr(`RG_ADDR_CTRL, 32'h0);
		rchk(`RG_ADDR_THRESH, 32'h17C);
		// High bus volts with regulation off leave decel alone
		volts <= 16'h0186;
		cur   <= 16'h00C8;
		tick(20);
		chk(32'(ramp_o.decel_stretch), 32'h0);
		chk(32'(ramp_o.accel_hold), 32'h0);
		wr(`RG_ADDR_CTRL, 32'h1);
		cur <= 16'h0000;
		tick(20);
		chk(32'(ramp_o.decel_stretch != 16'h0), 32'h1);
		// Current guard holds both ramps just above the limit
		volts <= 16'h0100;
		wr(`RG_ADDR_CTRL, 32'h2);
		cur <= 16'h0097;
		tick(20);
		chk(32'(ramp_o.accel_hold), 32'h1);
		chk(32'(ramp_o.decel_hold), 32'h1);
		cur <= 16'h0096;
		tick(20);
		chk(32'(ramp_o.accel_hold), 32'h0);
		chk(32'(ramp_o.decel_hold), 32'h0);
		// Carrier reduction only when enabled and loaded
		load <= 16'h00C8;
		tick(20);
		chk(32'(carrier_low_o), 32'h0);
		wr(`RG_ADDR_CTRL, 32'h4);
		tick(20);
		chk(32'(carrier_low_o), 32'h1);
		load <= 16'h000A;
		tick(20);
		chk(32'(carrier_low_o), 32'h0);
		// Output stage kept live while stopped with ready on
		wr(`RG_ADDR_CTRL, 32'h8);
		tick(3);
		chk(32'(stage_enable_o), 32'h1);
		wr(`RG_ADDR_CTRL, 32'h0);
		tick(3);
		chk(32'(stage_enable_o), 32'h0);
		run_i <= 1'b1;
		tick(3);
		chk(32'(stage_enable_o), 32'h1);
		// Terminal decoding with default functions
		tick(5);
		chk(32'(func_active_o), 32'h0);
		term_pin_i <= 5'h01;
		tick(5);
		chk(32'(func_active_o), 32'h1);
		// Terminals one and two share function five
		wr(`RG_ADDR_FUNC_LO, 32'h8A5);
		rchk(`RG_ADDR_FUNC_LO, 32'h8A5);
		term_pin_i <= 5'h02;
		tick(5);
		chk(32'(func_active_o), 32'h20);
		rchk(`RG_ADDR_STATUS, 32'h20);
		// Terminal one normally closed reads active with pin low
		wr(`RG_ADDR_CTRL, 32'h100);
		term_pin_i <= 5'h00;
		tick(5);
		chk(32'(func_active_o), 32'h20);
		// Thermistor code on terminal five
		chk(32'(thermistor_sel_o), 32'h0);
		wr(`RG_ADDR_FUNC_HI, 32'h263);
		tick(5);
		chk(32'(thermistor_sel_o), 32'h1);
		complete_run();
	end
endmodule
`default_nettype wire
